// ### verilog/rtcab_pkg.sv
// Package with constants, types and register map of the alarm/backup block
package rtcab_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int PULSE_US = 1000;
  localparam int PULSE_CYCLES = PULSE_US * CLK_MHZ;
  localparam int PULSE_CNT_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int NUM_FIELDS = 6;
  localparam logic [3:0] OFS_ALARM0_SECONDS = 4'h0;
  localparam logic [3:0] OFS_ALARM0_MINUTES = 4'h1;
  localparam logic [3:0] OFS_ALARM0_HOURS = 4'h2;
  localparam logic [3:0] OFS_ALARM0_DATE = 4'h3;
  localparam logic [3:0] OFS_ALARM0_MONTH = 4'h4;
  localparam logic [3:0] OFS_ALARM0_WEEKDAY = 4'h5;
  localparam logic [3:0] OFS_IRQ_CONFIG = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_BACKUP_CONFIG = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ALARM_EN_BIT = 7;
  localparam int CFG_PULSE_BIT = 7;
  localparam int CFG_ALARM0_ENABLE_BIT = 5;
  localparam int STS_AL0_BIT = 0;
  localparam int STS_BACKUP_BIT = 1;
  localparam int STS_PIN_BIT = 2;
  localparam int STS_SERIAL_BIT = 3;
  localparam int BKUP_BSW_BIT = 0;
  localparam int BKUP_SERIAL_BUS_BACKUP_INHIBIT_BIT_BIT = 1;
  localparam logic [7:0] RST_ALARM = 8'h00;
  localparam logic [7:0] RST_IRQ_CONFIG = 8'h00;
  localparam logic [7:0] RST_BACKUP_CONFIG = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Encoding is {serial_bus_backup_inhibit_bit, backup_switch_select}
  typedef enum logic [1:0] {
    MODE_A = 2'b00,
    MODE_B = 2'b01,
    MODE_C = 2'b10,
    MODE_D = 2'b11
  } rtcab_mode_t;

  typedef enum logic {
    IRQ_IDLE = 1'b0,
    IRQ_PULSE = 1'b1
  } rtcab_irq_state_t;

  // Current BCD time, field order matches register offsets 0..5
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtcab_time_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcab_reg_req_t;

  typedef struct packed {
    logic vdd_below_vbat;
    logic vdd_below_trip;
  } rtcab_supply_t;

endpackage

// ### verilog/rtcab_core.sv
// Alarm 0 matching, interrupt output and battery backup mode control
`timescale 1ns/10ps
// Functional notes
// - Standard backup: alarm stops, bus runs unless inhibited
// - Legacy backup: alarm works, bus works unless inhibited
// - Alarm bit 7 enables field, low bits target
// - No alarm unless alarm0_enable bit 5 set
// - Match checked as time advances, enabled fields
// - Match sets alarm0_flag and pulls irq low
// - Mode bit 0: single interrupt on match
// - Mode bit 1: pulse irq at every match
// - Pulsed mode re-fires without flag clearing
// - Four backup modes from two config bits
// - Standard: backup below lower of trip, vbat
// - Legacy: backup when main below backup supply
// - Modes A, B keep bus usable in backup
// - Mode C disables bus on backup supply
// - Mode D disables bus on backup supply
// - Irq output stays active in every mode
// - Decode inhibit/switch bits into modes A-D
module rtcab_core #(
  parameter int PULSE_CYCLES = rtcab_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register access from the serial bus engine
  input wire rtcab_pkg::rtcab_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Timekeeping
  input wire rtcab_pkg::rtcab_time_t time_in,
  input wire logic time_tick_in,
  // Supply comparators
  input wire rtcab_pkg::rtcab_supply_t supply_in,
  // Open-drain interrupt pin
  input wire logic irq_freq_output_in,
  output logic irq_freq_output_out,
  output logic irq_freq_output_oe_out,
  // Backup state
  output logic on_backup_out,
  output logic serial_enable_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] alarm_q [rtcab_pkg::NUM_FIELDS];
  logic [7:0] alarm_d [rtcab_pkg::NUM_FIELDS];
  logic [7:0] cfg_q, cfg_d, bkup_q, bkup_d;
  logic flag_q, flag_d, backup_q, backup_d, serial_q, serial_d;
  logic irq_q, irq_d, rvalid_q, rvalid_d, drive_q, drive_d;
  logic [7:0] rdata_q, rdata_d;
  logic [rtcab_pkg::PULSE_CNT_W-1:0] cnt_q, cnt_d;
  rtcab_pkg::rtcab_irq_state_t state_q, state_d;
  rtcab_pkg::rtcab_mode_t mode;
  logic [rtcab_pkg::NUM_FIELDS-1:0] field_ok;
  logic [7:0] time_field [rtcab_pkg::NUM_FIELDS];
  logic legacy, inhibit, enter_backup, alarm_ok, fire, pulse_mode;
  logic wr_ok, rd_ok, sts_clear;
  localparam logic [rtcab_pkg::PULSE_CNT_W-1:0] PULSE_LAST =
    rtcab_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Mode decode and supply switchover
  // ----------------------------------------------------------------
  assign mode = rtcab_pkg::rtcab_mode_t'({bkup_q[rtcab_pkg::BKUP_SERIAL_BUS_BACKUP_INHIBIT_BIT_BIT],
    bkup_q[rtcab_pkg::BKUP_BSW_BIT]});
  assign legacy = (mode == rtcab_pkg::MODE_B) || (mode == rtcab_pkg::MODE_D);
  assign inhibit = (mode == rtcab_pkg::MODE_C) || (mode == rtcab_pkg::MODE_D);

  always_comb
  begin
    if (legacy)
    begin
      enter_backup = supply_in.vdd_below_vbat;
    end
    else
    begin
      // Below the lower threshold means below both
      enter_backup = supply_in.vdd_below_vbat &&
        supply_in.vdd_below_trip;
    end
    backup_d = enter_backup;
    serial_d = !backup_q || !inhibit;
    alarm_ok = !backup_q || legacy;
  end

  // ----------------------------------------------------------------
  // Alarm compare
  // ----------------------------------------------------------------
  assign time_field[0] = time_in.seconds;
  assign time_field[1] = time_in.minutes;
  assign time_field[2] = time_in.hours;
  assign time_field[3] = time_in.date;
  assign time_field[4] = time_in.month;
  assign time_field[5] = time_in.weekday;

  for (genvar i = 0; i < rtcab_pkg::NUM_FIELDS; i++)
  begin : g_field
    // Disabled field always agrees
    assign field_ok[i] = !alarm_q[i][rtcab_pkg::ALARM_EN_BIT] ||
      (alarm_q[i][rtcab_pkg::ALARM_EN_BIT-1:0] ==
       time_field[i][rtcab_pkg::ALARM_EN_BIT-1:0]);
  end

  assign pulse_mode = cfg_q[rtcab_pkg::CFG_PULSE_BIT];
  assign fire = time_tick_in && (&field_ok) && alarm_ok &&
    cfg_q[rtcab_pkg::CFG_ALARM0_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  assign wr_ok = reg_req_in.wr && serial_q;
  assign rd_ok = reg_req_in.rd && serial_q;
  assign sts_clear = wr_ok && (reg_req_in.addr == rtcab_pkg::OFS_STATUS) &&
    reg_req_in.wdata[rtcab_pkg::STS_AL0_BIT];

  always_comb
  begin
    cfg_d = cfg_q;
    bkup_d = bkup_q;
    for (int i = 0; i < rtcab_pkg::NUM_FIELDS; i++)
    begin
      alarm_d[i] = alarm_q[i];
      if (wr_ok && (reg_req_in.addr == 4'(i)))
      begin
        alarm_d[i] = reg_req_in.wdata;
      end
    end
    if (wr_ok && (reg_req_in.addr == rtcab_pkg::OFS_IRQ_CONFIG))
    begin
      cfg_d = reg_req_in.wdata;
    end
    if (wr_ok && (reg_req_in.addr == rtcab_pkg::OFS_BACKUP_CONFIG))
    begin
      bkup_d = reg_req_in.wdata;
    end
    rvalid_d = rd_ok;
    rdata_d = rdata_q;
    if (rd_ok)
    begin
      case (reg_req_in.addr)
        rtcab_pkg::OFS_ALARM0_SECONDS: rdata_d = alarm_q[0];
        rtcab_pkg::OFS_ALARM0_MINUTES: rdata_d = alarm_q[1];
        rtcab_pkg::OFS_ALARM0_HOURS: rdata_d = alarm_q[2];
        rtcab_pkg::OFS_ALARM0_DATE: rdata_d = alarm_q[3];
        rtcab_pkg::OFS_ALARM0_MONTH: rdata_d = alarm_q[4];
        rtcab_pkg::OFS_ALARM0_WEEKDAY: rdata_d = alarm_q[5];
        rtcab_pkg::OFS_IRQ_CONFIG: rdata_d = cfg_q;
        rtcab_pkg::OFS_BACKUP_CONFIG: rdata_d = bkup_q;
        rtcab_pkg::OFS_STATUS:
        begin
          rdata_d = rtcab_pkg::READ_ZERO;
          rdata_d[rtcab_pkg::STS_AL0_BIT] = flag_q;
          rdata_d[rtcab_pkg::STS_BACKUP_BIT] = backup_q;
          rdata_d[rtcab_pkg::STS_PIN_BIT] = irq_freq_output_in;
          rdata_d[rtcab_pkg::STS_SERIAL_BIT] = serial_q;
        end
        default: rdata_d = rtcab_pkg::READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag and interrupt pin
  // ----------------------------------------------------------------
  always_comb
  begin
    // Open-drain pin only ever sinks; the enable decides when
    drive_d = 1'b0;
    // A match in the clearing cycle wins
    flag_d = fire || (flag_q && !sts_clear);
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      rtcab_pkg::IRQ_IDLE:
      begin
        if (fire && pulse_mode)
        begin
          state_d = rtcab_pkg::IRQ_PULSE;
          cnt_d = '0;
        end
      end
      rtcab_pkg::IRQ_PULSE:
      begin
        if (fire)
        begin
          cnt_d = '0;
        end
        else if (cnt_q == PULSE_LAST)
        begin
          state_d = rtcab_pkg::IRQ_IDLE;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: state_d = rtcab_pkg::IRQ_IDLE;
    endcase
    // Not gated by backup state
    if (pulse_mode)
    begin
      irq_d = (state_d == rtcab_pkg::IRQ_PULSE);
    end
    else
    begin
      irq_d = flag_d;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < rtcab_pkg::NUM_FIELDS; i++)
      begin
        alarm_q[i] <= rtcab_pkg::RST_ALARM;
      end
      cfg_q <= rtcab_pkg::RST_IRQ_CONFIG;
      bkup_q <= rtcab_pkg::RST_BACKUP_CONFIG;
      flag_q <= 1'b0;
      backup_q <= 1'b0;
      serial_q <= 1'b1;
      irq_q <= 1'b0;
      drive_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= rtcab_pkg::READ_ZERO;
      cnt_q <= '0;
      state_q <= rtcab_pkg::IRQ_IDLE;
    end
    else
    begin
      alarm_q <= alarm_d;
      cfg_q <= cfg_d;
      bkup_q <= bkup_d;
      flag_q <= flag_d;
      backup_q <= backup_d;
      serial_q <= serial_d;
      irq_q <= irq_d;
      drive_q <= drive_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign irq_freq_output_out = drive_q;
  assign irq_freq_output_oe_out = irq_q;
  assign on_backup_out = backup_q;
  assign serial_enable_out = serial_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_match_sets_flag: assert property (fire |=> flag_q)
    else $error("alarm match did not set flag");
  a_flag_needs_enable: assert property (
    $rose(flag_q) |->
    $past(cfg_q[rtcab_pkg::CFG_ALARM0_ENABLE_BIT]) && $past(time_tick_in))
    else $error("flag set without enable or tick");
  a_single_pin_flag: assert property (
    !pulse_mode && !$past(pulse_mode) |-> irq_freq_output_oe_out == flag_q)
    else $error("single mode pin does not follow flag");
  a_pulse_starts: assert property (
    fire && pulse_mode |=>
    irq_freq_output_oe_out && state_q == rtcab_pkg::IRQ_PULSE)
    else $error("pulse did not start on match");
  a_pulse_bounded: assert property (
    state_q == rtcab_pkg::IRQ_PULSE |-> cnt_q <= PULSE_LAST)
    else $error("pulse longer than its length");
  a_pulse_ends: assert property (
    state_q == rtcab_pkg::IRQ_PULSE && cnt_q == PULSE_LAST && !fire &&
    pulse_mode |=> !irq_freq_output_oe_out)
    else $error("pulse did not end after its length");
  a_pulse_no_clear: assert property (
    fire && pulse_mode && flag_q |=> irq_freq_output_oe_out && flag_q)
    else $error("pulsed mode needs flag clear");
  a_legacy_entry: assert property (
    supply_in.vdd_below_vbat && legacy |=> on_backup_out)
    else $error("legacy switchover missed");
  a_std_entry: assert property (
    !supply_in.vdd_below_trip && !legacy |=> !on_backup_out)
    else $error("standard switchover too early");
  a_bus_blocked: assert property (
    backup_q && inhibit |=> !serial_enable_out ##1 !reg_rvalid_out)
    else $error("bus not disabled in backup");
  a_bus_kept: assert property (
    backup_q && !inhibit |=> serial_enable_out)
    else $error("bus lost in mode A or B");
  a_std_no_alarm: assert property (
    backup_q && !legacy |=> !$rose(flag_q))
    else $error("alarm in standard backup");

  c_single_fire: cover property (fire && !pulse_mode);
  c_pulse_refire: cover property (fire && pulse_mode ##[1:100] fire);
  c_backup_blocked: cover property (backup_q && mode == rtcab_pkg::MODE_D);
  c_legacy_alarm: cover property (fire && backup_q);

endmodule // rtcab_core

// ### verif/rtcab_host_model.sv
// Host model: register accesses and the pull-up on the interrupt pin
`timescale 1ns/10ps
module rtcab_host_model (
  // Clock
  input wire logic clk_in,
  // Device side
  input wire logic irq_oe_in,
  input wire logic reg_rvalid_in,
  input wire logic [7:0] reg_rdata_in,
  output rtcab_pkg::rtcab_reg_req_t reg_req_out,
  output logic pin_level_out
);
  // Pull-up keeps the open-drain pin high unless the device sinks it
  assign pin_level_out = irq_oe_in ? 1'b0 : 1'b1;
  initial reg_req_out = '0;

  // Idle bus shows the inverse of the last address and data
  task automatic drive(input logic wr, input logic [3:0] addr,
                       input logic [7:0] wdata);
    @(negedge clk_in);
    reg_req_out = {wr, ~wr, addr, wdata};
    @(negedge clk_in);
    reg_req_out = {1'b0, 1'b0, ~addr, ~wdata};
  endtask

  task automatic wr_reg(input logic [3:0] addr, input logic [7:0] wdata);
    drive(1'b1, addr, wdata);
  endtask

  task automatic rd_reg(input logic [3:0] addr, output logic [7:0] data,
                        output logic got);
    got = 1'b0;
    data = 8'h00;
    @(negedge clk_in);
    reg_req_out = {1'b0, 1'b1, addr, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk_in);
      if (reg_rvalid_in === 1'b1 && !got)
      begin
        got = 1'b1;
        data = reg_rdata_in;
      end
      if (i == 0)
        reg_req_out = {1'b0, 1'b0, ~addr, 8'hff};
    end
  endtask
endmodule // rtcab_host_model

// ### verif/tb.sv
// Self-checking testbench of the alarm and backup mode block
`timescale 1ns/10ps
module tb;
  localparam int PULSE = 8;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  rtcab_pkg::rtcab_reg_req_t reg_req;
  rtcab_pkg::rtcab_time_t time_v = '0;
  rtcab_pkg::rtcab_supply_t supply = '0;
  logic tick = 1'b0;
  logic pin, oe, on_backup, ser_en, rvalid, got, pin_drv;
  logic [7:0] rdata, rd;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  always #12.5 clk_in = ~clk_in;

  rtcab_core #(.PULSE_CYCLES(PULSE)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .time_in(time_v),
    .time_tick_in(tick), .supply_in(supply), .irq_freq_output_in(pin),
    .irq_freq_output_out(pin_drv), .irq_freq_output_oe_out(oe),
    .on_backup_out(on_backup), .serial_enable_out(ser_en));

  rtcab_host_model host (
    .clk_in(clk_in), .irq_oe_in(oe), .reg_rvalid_in(rvalid),
    .reg_rdata_in(rdata), .reg_req_out(reg_req), .pin_level_out(pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got_v, input logic [7:0] exp);
    compares++;
    if (got_v !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got_v, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic do_tick(input logic [7:0] mi, input logic [7:0] se);
    @(negedge clk_in);
    time_v = {8'h03, 8'h01, 8'h01, 8'h11, mi, se};
    tick = 1'b1;
    @(negedge clk_in);
    tick = 1'b0;
    @(negedge clk_in);
  endtask

  task automatic read_chk(input logic [3:0] a, input logic [7:0] exp);
    host.rd_reg(a, rd, got);
    check_val({7'h00, got}, 8'h01);
    check_val(rd, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    read_chk(rtcab_pkg::OFS_STATUS, 8'h0c);
    check_val({7'h00, pin_drv}, 8'h00);
    read_chk(rtcab_pkg::OFS_IRQ_CONFIG, 8'h00);
    read_chk(4'h9, 8'h00);
  endtask

  task automatic t_single;
    logic [7:0] tbl [6];
    tbl = '{8'h00, 8'hb0, 8'h91, 8'h81, 8'h81, 8'h00};
    for (int i = 0; i < 6; i++)
      host.wr_reg(4'(i), tbl[i]);
    do_tick(8'h30, 8'h00);
    check_val({7'h00, oe}, 8'h00);
    host.wr_reg(rtcab_pkg::OFS_IRQ_CONFIG, 8'h20);
    do_tick(8'h29, 8'h00);
    check_val({7'h00, oe}, 8'h00);
    do_tick(8'h30, 8'h00);
    check_val({7'h00, oe}, 8'h01);
    check_val({7'h00, pin_drv}, 8'h00);
    read_chk(rtcab_pkg::OFS_ALARM0_MINUTES, 8'hb0);
    wait_cyc(PULSE + 4);
    check_val({7'h00, oe}, 8'h01);
    read_chk(rtcab_pkg::OFS_STATUS, 8'h09);
    host.wr_reg(rtcab_pkg::OFS_STATUS, 8'h01);
    wait_cyc(2);
    check_val({7'h00, oe}, 8'h00);
  endtask

  task automatic t_pulse;
    host.wr_reg(rtcab_pkg::OFS_ALARM0_SECONDS, 8'hb0);
    for (int i = 1; i < 6; i++)
      host.wr_reg(4'(i), 8'h00);
    host.wr_reg(rtcab_pkg::OFS_IRQ_CONFIG, 8'ha0);
    for (int k = 0; k < 2; k++)
    begin
      do_tick(8'(k), 8'h30);
      check_val({7'h00, oe}, 8'h01);
      wait_cyc(PULSE + 2);
      check_val({7'h00, oe}, 8'h00);
      read_chk(rtcab_pkg::OFS_STATUS, 8'h0d);
    end
  endtask

  task automatic t_backup;
    for (int m = 0; m < 4; m++)
    begin
      host.wr_reg(rtcab_pkg::OFS_BACKUP_CONFIG, 8'(m));
      host.wr_reg(rtcab_pkg::OFS_STATUS, 8'h01);
      supply = 2'b10;
      wait_cyc(3);
      check_val({7'h00, on_backup}, 8'(m & 1));
      supply = 2'b11;
      wait_cyc(3);
      check_val({7'h00, on_backup}, 8'h01);
      check_val({7'h00, ser_en}, 8'(m < 2));
      host.rd_reg(rtcab_pkg::OFS_IRQ_CONFIG, rd, got);
      check_val({7'h00, got}, 8'(m < 2));
      check_val(rd, (m < 2) ? 8'ha0 : 8'h00);
      do_tick(8'h05, 8'h30);
      check_val({7'h00, oe}, 8'(m & 1));
      check_val({7'h00, pin}, 8'(~m & 1));
      wait_cyc(PULSE + 2);
      supply = 2'b00;
      wait_cyc(3);
      check_val({7'h00, ser_en}, 8'h01);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    wait_cyc(2);
    reset_n_in = 1'b1;
    t_reset();
    t_single();
    t_pulse();
    t_backup();
    tally_and_finish();
  end
endmodule // tb
